//--- pkg/pmwg_consts.svh
// Constants of the program memory write guard: widths, field positions, offsets, reset values
`ifndef PMWG_CONSTS_SVH
`define PMWG_CONSTS_SVH

// ----------------------------------------
// Address geometry
// ----------------------------------------
`define PMWG_ADDR_W 24
`define PMWG_PAGE_LSB 9
`define PMWG_PAGE_W 15
`define PMWG_SEG_W 9
`define PMWG_FIRST_PAGE 15'h0000
// Last implemented page, holds the configuration words
`define PMWG_LAST_PAGE 15'h00ff

// ----------------------------------------
// Configuration word layout
// ----------------------------------------
`define PMWG_CFG_W 16
`define PMWG_CFG_PAGE_MSB 8
`define PMWG_CFG_BOUNDARY_BIT 9
`define PMWG_CFG_CFGPAGE_BIT 10
`define PMWG_CFG_SEGDIS_BIT 11
`define PMWG_CFG_GWP_BIT 12
`define PMWG_CFG_GCP_BIT 13
`define PMWG_CFG_UNLOADED 16'hffff

// ----------------------------------------
// Register port
// ----------------------------------------
`define PMWG_REG_AW 4
`define PMWG_REG_DW 16
`define PMWG_REG_CTRL 4'h0
`define PMWG_REG_STATUS 4'h1
`define PMWG_REG_CFG 4'h2
`define PMWG_REG_DENY_CNT 4'h3
`define PMWG_REG_CAUSE 4'h4
`define PMWG_CTRL_RESET 16'h0000
`define PMWG_CTRL_ARM_BIT 0
`define PMWG_CTRL_ARM_RESET 1'b0
`define PMWG_ST_NVM_DENY_BIT 0
`define PMWG_ST_PROG_DENY_BIT 1
`define PMWG_ST_LOADED_BIT 2
`define PMWG_ST_FAULT_BIT 3
`define PMWG_CNT_MAX 16'hffff
`define PMWG_CNT_ONE 16'h0001
`define PMWG_NVM_CAUSE_W 5
`define PMWG_PROG_CAUSE_W 4
`define PMWG_CAUSE_PROG_LSB 8

`endif

//--- pkg/pmwg_pkg.sv
// Types of the program memory write guard
`include "pmwg_consts.svh"
package pmwg_pkg;
  typedef struct packed {
    logic global_code_protect;
    logic global_write_protect;
    logic segment_protect_disable;
    logic config_page_protect;
    logic segment_boundary_select;
    logic [`PMWG_SEG_W-1:0] segment_page_number;
  } pmwg_cfg_s;

  typedef enum logic [2:0] {
    PMWG_ST_EMPTY = 3'b001,
    PMWG_ST_LOADED = 3'b010,
    PMWG_ST_FAULT = 3'b100
  } pmwg_chk_e;

  typedef logic [`PMWG_ADDR_W-1:0] pmwg_addr_t;
endpackage

//--- pkg/pmwg_cfg_if.sv
// Carrier between the guard and its configuration checker
`timescale 1ns/1ps
`default_nettype none
`include "pmwg_consts.svh"
interface pmwg_cfg_if;
  import pmwg_pkg::*;
  logic load;
  logic [`PMWG_CFG_W-1:0] load_word;
  pmwg_cfg_s cfg;
  logic valid;
  logic fault;
  modport chk (input load, input load_word, output cfg, output valid, output fault);
  modport guard (output load, output load_word, input cfg, input valid, input fault);
endinterface
`default_nettype wire

//--- core/pmwg_cfg_check.sv
// Configuration register with complementary shadow and parity checking
`timescale 1ns/1ps
`default_nettype none
`include "pmwg_consts.svh"
module pmwg_cfg_check (
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  pmwg_cfg_if.chk cfg_io
);
  import pmwg_pkg::*;

  logic [`PMWG_CFG_W-1:0] cfg_q;
  logic [`PMWG_CFG_W-1:0] shadow_q;
  logic par_q;
  logic fault_q;
  pmwg_chk_e st_q;
  logic mismatch;

  // ----------------------------------------
  // Stored copy, complement and parity
  // ----------------------------------------
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cfg_q <= `PMWG_CFG_UNLOADED;
      shadow_q <= ~`PMWG_CFG_UNLOADED;
      par_q <= ^`PMWG_CFG_UNLOADED;
    end else if (cfg_io.load && st_q != PMWG_ST_FAULT) begin
      cfg_q <= cfg_io.load_word;
      shadow_q <= ~cfg_io.load_word;
      par_q <= ^cfg_io.load_word;
    end
  end

  // Shadow must stay the complement; a flipped cell also breaks parity
  assign mismatch = (cfg_q != ~shadow_q) || ((^cfg_q) != par_q);

  // ----------------------------------------
  // Check state
  // ----------------------------------------
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st_q <= PMWG_ST_EMPTY;
      fault_q <= 1'b0;
    end else begin
      case (st_q)
        PMWG_ST_EMPTY: begin
          if (cfg_io.load) begin
            st_q <= PMWG_ST_LOADED;
          end
        end
        PMWG_ST_LOADED: begin
          // A load in progress rewrites all three copies, so skip that cycle
          if (mismatch && !cfg_io.load) begin
            st_q <= PMWG_ST_FAULT;
            fault_q <= 1'b1;
          end
        end
        PMWG_ST_FAULT: begin
          // Only a device reset leaves this state
          fault_q <= 1'b1;
        end
        default: begin
          st_q <= PMWG_ST_FAULT;
          fault_q <= 1'b1;
        end
      endcase
    end
  end

  assign cfg_io.fault = fault_q;
  assign cfg_io.valid = (st_q == PMWG_ST_LOADED);
  assign cfg_io.cfg.global_code_protect = cfg_q[`PMWG_CFG_GCP_BIT];
  assign cfg_io.cfg.global_write_protect = cfg_q[`PMWG_CFG_GWP_BIT];
  assign cfg_io.cfg.segment_protect_disable = cfg_q[`PMWG_CFG_SEGDIS_BIT];
  assign cfg_io.cfg.config_page_protect = cfg_q[`PMWG_CFG_CFGPAGE_BIT];
  assign cfg_io.cfg.segment_boundary_select = cfg_q[`PMWG_CFG_BOUNDARY_BIT];
  assign cfg_io.cfg.segment_page_number = cfg_q[`PMWG_CFG_PAGE_MSB:0];
endmodule
`default_nettype wire

//--- core/pmwg_guard.sv
// Program memory write guard: checks sequencer and programmer accesses against protection
`timescale 1ns/1ps
`default_nettype none
`include "pmwg_consts.svh"

module pmwg_guard (
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire logic cfg_load_in,
  input wire logic [`PMWG_CFG_W-1:0] cfg_word_in,
  input wire logic nvm_req_in,
  input wire logic nvm_erase_in,
  input wire pmwg_pkg::pmwg_addr_t nvm_addr_in,
  output logic nvm_grant_out,
  output logic nvm_deny_out,
  input wire logic prog_req_in,
  input wire logic prog_write_in,
  input wire pmwg_pkg::pmwg_addr_t prog_addr_in,
  output logic prog_grant_out,
  output logic prog_deny_out,
  output logic device_reset_out,
  input wire logic [`PMWG_REG_AW-1:0] reg_addr_in,
  input wire logic [`PMWG_REG_DW-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [`PMWG_REG_DW-1:0] reg_rdata_out
);
  import pmwg_pkg::*;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [`PMWG_PAGE_W-1:0] page_of(input pmwg_addr_t addr);
    page_of = addr[`PMWG_ADDR_W-1:`PMWG_PAGE_LSB];
  endfunction

  // Segment hit for one page; both protect settings read as programmed-0 = active, boundary select 0 = pages up to the number
  function automatic logic seg_hit(input pmwg_cfg_s c, input logic [`PMWG_PAGE_W-1:0] pg);
    logic [`PMWG_PAGE_W-1:0] sel;
    logic hit;
    sel = {{(`PMWG_PAGE_W-`PMWG_SEG_W){1'b0}}, c.segment_page_number};
    hit = 1'b0;
    if (!c.segment_protect_disable) begin
      if (!c.segment_boundary_select) begin
        hit = (pg <= sel);
      end else begin
        hit = (pg >= sel) && (pg <= `PMWG_LAST_PAGE);
      end
    end
    if (!c.config_page_protect && pg == `PMWG_LAST_PAGE) begin
      hit = 1'b1;
    end
    // Both disables at 1 leave hit low here: only global checks remain
    seg_hit = hit;
  endfunction

  function automatic logic in_memory(input logic [`PMWG_PAGE_W-1:0] pg);
    in_memory = (pg <= `PMWG_LAST_PAGE);
  endfunction

  // Register index decode, shared by every register write
  function automatic logic reg_sel(input logic [`PMWG_REG_AW-1:0] a, input logic [`PMWG_REG_AW-1:0] idx);
    reg_sel = (a == idx);
  endfunction

  // ----------------------------------------
  // Configuration checker
  // ----------------------------------------
  pmwg_cfg_if cfg_bus ();

  assign cfg_bus.load = cfg_load_in;
  assign cfg_bus.load_word = cfg_word_in;

  pmwg_cfg_check u_cfg_check (
    .clk_sys_in(clk_sys_in),
    .resetn_in(resetn_in),
    .cfg_io(cfg_bus.chk)
  );

  logic code_protect_on;
  logic write_protect_on;
  assign code_protect_on = !cfg_bus.cfg.global_code_protect;
  assign write_protect_on = !cfg_bus.cfg.global_write_protect;

  // ----------------------------------------
  // Decisions
  // ----------------------------------------
  logic [`PMWG_PAGE_W-1:0] nvm_page;
  logic [`PMWG_PAGE_W-1:0] prog_page;
  logic cfg_ready;
  logic nvm_unarmed;
  logic nvm_out_of_range;
  logic nvm_wp_refuse;
  logic nvm_seg_refuse;
  logic prog_out_of_range;
  logic prog_cp_refuse;
  logic prog_seg_refuse;
  logic nvm_ok;
  logic prog_ok;
  logic arm_q;

  assign nvm_page = page_of(nvm_addr_in);
  assign prog_page = page_of(prog_addr_in);
  // Nothing is granted before a clean load, nor after a shadow or parity fault
  assign cfg_ready = cfg_bus.valid && !cfg_bus.fault;

  // Writes and erases share one check: an erase damages as much as a write
  assign nvm_unarmed = !arm_q;
  assign nvm_out_of_range = !in_memory(nvm_page);
  assign nvm_wp_refuse = write_protect_on;
  assign nvm_seg_refuse = seg_hit(cfg_bus.cfg, nvm_page);
  // Each check can only refuse; none can lift another
  assign nvm_ok = cfg_ready && !(nvm_unarmed || nvm_out_of_range || nvm_wp_refuse || nvm_seg_refuse);

  // Code protect covers the configuration words as well, being in the last page
  assign prog_out_of_range = !in_memory(prog_page);
  assign prog_cp_refuse = code_protect_on;
  assign prog_seg_refuse = prog_write_in && seg_hit(cfg_bus.cfg, prog_page);
  assign prog_ok = cfg_ready && !(prog_out_of_range || prog_cp_refuse || prog_seg_refuse);

  // ----------------------------------------
  // Answers, one cycle after the request
  // ----------------------------------------
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      nvm_grant_out <= 1'b0;
      nvm_deny_out <= 1'b0;
    end else begin
      nvm_grant_out <= nvm_req_in && nvm_ok;
      nvm_deny_out <= nvm_req_in && !nvm_ok;
    end
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      prog_grant_out <= 1'b0;
      prog_deny_out <= 1'b0;
    end else begin
      prog_grant_out <= prog_req_in && prog_ok;
      prog_deny_out <= prog_req_in && !prog_ok;
    end
  end

  // Held until the reset it requests comes back to clear it
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      device_reset_out <= 1'b0;
    end else if (cfg_bus.fault) begin
      device_reset_out <= 1'b1;
    end
  end

  // ----------------------------------------
  // Register port
  // ----------------------------------------
  logic wr_ctrl;
  logic wr_status;
  logic wr_cnt;
  logic nvm_deny_q;
  logic prog_deny_q;
  logic [`PMWG_REG_DW-1:0] deny_cnt_q;
  logic [`PMWG_NVM_CAUSE_W-1:0] nvm_cause_q;
  logic [`PMWG_PROG_CAUSE_W-1:0] prog_cause_q;
  logic nvm_deny_ev;
  logic prog_deny_ev;

  assign wr_ctrl = reg_wr_in && reg_sel(reg_addr_in, `PMWG_REG_CTRL);
  assign wr_status = reg_wr_in && reg_sel(reg_addr_in, `PMWG_REG_STATUS);
  assign wr_cnt = reg_wr_in && reg_sel(reg_addr_in, `PMWG_REG_DENY_CNT);
  assign nvm_deny_ev = nvm_req_in && !nvm_ok;
  assign prog_deny_ev = prog_req_in && !prog_ok;

  // Software must arm the interlock before the sequencer may write
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      arm_q <= `PMWG_CTRL_ARM_RESET;
    end else if (wr_ctrl) begin
      arm_q <= reg_wdata_in[`PMWG_CTRL_ARM_BIT];
    end
  end

  // ----------------------------------------
  // Refusal flags
  // ----------------------------------------
  // Sticky, write one to clear; a new refusal wins over the clear
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      nvm_deny_q <= 1'b0;
    end else if (nvm_deny_ev) begin
      nvm_deny_q <= 1'b1;
    end else if (wr_status && reg_wdata_in[`PMWG_ST_NVM_DENY_BIT]) begin
      nvm_deny_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      prog_deny_q <= 1'b0;
    end else if (prog_deny_ev) begin
      prog_deny_q <= 1'b1;
    end else if (wr_status && reg_wdata_in[`PMWG_ST_PROG_DENY_BIT]) begin
      prog_deny_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // Refusal count
  // ----------------------------------------
  // Saturating; any write to it clears it, refusal wins
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      deny_cnt_q <= '0;
    end else if ((nvm_deny_ev || prog_deny_ev) && deny_cnt_q != `PMWG_CNT_MAX) begin
      deny_cnt_q <= deny_cnt_q + `PMWG_CNT_ONE;
    end else if (wr_cnt && !(nvm_deny_ev || prog_deny_ev)) begin
      deny_cnt_q <= '0;
    end
  end

  // ----------------------------------------
  // Refusal causes
  // ----------------------------------------
  // Lets software tell a locked segment from a missing arm or an unloaded word
  // Bits from low to high: not ready, unarmed, out of range, write protect, segment
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      nvm_cause_q <= '0;
    end else if (nvm_deny_ev) begin
      nvm_cause_q <= {nvm_seg_refuse, nvm_wp_refuse, nvm_out_of_range, nvm_unarmed, !cfg_ready};
    end
  end

  // Bits from low to high: not ready, out of range, code protect, segment
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      prog_cause_q <= '0;
    end else if (prog_deny_ev) begin
      prog_cause_q <= {prog_seg_refuse, prog_cp_refuse, prog_out_of_range, !cfg_ready};
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  logic [`PMWG_REG_DW-1:0] rd_val;
  always_comb begin
    rd_val = '0;
    case (reg_addr_in)
      `PMWG_REG_CTRL: begin
        rd_val[`PMWG_CTRL_ARM_BIT] = arm_q;
      end
      `PMWG_REG_STATUS: begin
        rd_val[`PMWG_ST_NVM_DENY_BIT] = nvm_deny_q;
        rd_val[`PMWG_ST_PROG_DENY_BIT] = prog_deny_q;
        rd_val[`PMWG_ST_LOADED_BIT] = cfg_bus.valid;
        rd_val[`PMWG_ST_FAULT_BIT] = cfg_bus.fault;
      end
      `PMWG_REG_CFG: begin
        rd_val[`PMWG_CFG_PAGE_MSB:0] = cfg_bus.cfg.segment_page_number;
        rd_val[`PMWG_CFG_BOUNDARY_BIT] = cfg_bus.cfg.segment_boundary_select;
        rd_val[`PMWG_CFG_CFGPAGE_BIT] = cfg_bus.cfg.config_page_protect;
        rd_val[`PMWG_CFG_SEGDIS_BIT] = cfg_bus.cfg.segment_protect_disable;
        rd_val[`PMWG_CFG_GWP_BIT] = cfg_bus.cfg.global_write_protect;
        rd_val[`PMWG_CFG_GCP_BIT] = cfg_bus.cfg.global_code_protect;
      end
      `PMWG_REG_DENY_CNT: begin
        rd_val = deny_cnt_q;
      end
      `PMWG_REG_CAUSE: begin
        rd_val[`PMWG_NVM_CAUSE_W-1:0] = nvm_cause_q;
        rd_val[`PMWG_CAUSE_PROG_LSB +: `PMWG_PROG_CAUSE_W] = prog_cause_q;
      end
      default: begin
        rd_val = '0;
      end
    endcase
  end

  // Read data stands for the one cycle after the strobe only
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      reg_rdata_out <= '0;
    end else if (reg_rd_in) begin
      reg_rdata_out <= rd_val;
    end else begin
      reg_rdata_out <= '0;
    end
  end

  // Erase is only distinguished by the sequencer; the guard treats it as a write
  logic unused_erase;
  assign unused_erase = nvm_erase_in;
endmodule
`default_nettype wire

//--- tb/pmwg_guard_assertions.sv
// Port-level checker of the program memory write guard
`timescale 1ns/1ps
`default_nettype none
`include "pmwg_consts.svh"
module pmwg_guard_assertions (
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire logic cfg_load_in,
  input wire logic [`PMWG_CFG_W-1:0] cfg_word_in,
  input wire logic nvm_req_in,
  input wire pmwg_pkg::pmwg_addr_t nvm_addr_in,
  input wire logic nvm_grant_out,
  input wire logic nvm_deny_out,
  input wire logic prog_req_in,
  input wire logic prog_write_in,
  input wire pmwg_pkg::pmwg_addr_t prog_addr_in,
  input wire logic prog_grant_out,
  input wire logic prog_deny_out,
  input wire logic device_reset_out
);
  import pmwg_pkg::*;
  logic [15:0] w_q;
  logic ld_q;
  function automatic logic hit(input logic [15:0] c, input logic [14:0] p);
    return (!c[11] && (c[9] ? p >= {6'h00, c[8:0]} : p <= {6'h00, c[8:0]})) || (!c[10] && p == 15'h00ff);
  endfunction
  // Tracks the last loaded word; a load in fault is ignored by the guard but then everything is refused
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      w_q <= 16'hffff;
      ld_q <= 1'b0;
    end else if (cfg_load_in) begin
      w_q <= cfg_word_in;
      ld_q <= 1'b1;
    end
  end
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!resetn_in);
  AST_NVM_ONE: assert property (nvm_req_in |=> nvm_grant_out != nvm_deny_out)
    else $error("sequencer request not answered once");
  AST_NVM_QUIET: assert property (!nvm_req_in |=> !nvm_grant_out && !nvm_deny_out)
    else $error("sequencer answer without request");
  AST_PROG_ONE: assert property (prog_req_in |=> prog_grant_out != prog_deny_out)
    else $error("programmer request not answered once");
  AST_GWP: assert property (nvm_req_in && ld_q && !w_q[12] |=> nvm_deny_out)
    else $error("write protect did not refuse");
  AST_GCP: assert property (prog_req_in && ld_q && !w_q[13] |=> prog_deny_out)
    else $error("code protect did not refuse programmer");
  AST_SEG: assert property (nvm_req_in && hit(w_q, nvm_addr_in[23:9]) |=> nvm_deny_out)
    else $error("segment write granted");
  AST_PSEG: assert property (prog_req_in && prog_write_in && hit(w_q, prog_addr_in[23:9]) |=> prog_deny_out)
    else $error("programmer segment write granted");
  AST_RANGE: assert property (nvm_req_in && nvm_addr_in[23:9] > 15'h00ff |=> nvm_deny_out)
    else $error("write beyond last page granted");
  AST_READ_OK: assert property (prog_req_in && !prog_write_in && ld_q && w_q[13] && !device_reset_out
    && prog_addr_in[23:9] <= 15'h00ff |=> prog_grant_out)
    else $error("unprotected programmer read refused");
  AST_RST_HOLD: assert property (!$fell(device_reset_out))
    else $error("device reset request dropped");
endmodule
bind pmwg_guard pmwg_guard_assertions pmwg_guard_assertions_i (
  .clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .cfg_load_in(cfg_load_in), .cfg_word_in(cfg_word_in),
  .nvm_req_in(nvm_req_in), .nvm_addr_in(nvm_addr_in), .nvm_grant_out(nvm_grant_out), .nvm_deny_out(nvm_deny_out),
  .prog_req_in(prog_req_in), .prog_write_in(prog_write_in), .prog_addr_in(prog_addr_in),
  .prog_grant_out(prog_grant_out), .prog_deny_out(prog_deny_out), .device_reset_out(device_reset_out));
`default_nettype wire

//--- tb/pmwg_seq_model.sv
// Behavioural write/erase sequencer facing the guard
`timescale 1ns/1ps
`default_nettype none
module pmwg_seq_model (
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire logic go_in,
  input wire logic erase_in,
  input wire pmwg_pkg::pmwg_addr_t addr_in,
  input wire logic grant_in,
  output logic req_out,
  output logic erase_out,
  output pmwg_pkg::pmwg_addr_t addr_out,
  output logic [15:0] commits_out
);
  import pmwg_pkg::*;
  // Address and kind qualify only the request cycle; toggled otherwise so stale values cannot pass
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      req_out <= 1'b0;
      erase_out <= 1'b0;
      addr_out <= '0;
    end else begin
      req_out <= go_in;
      erase_out <= go_in ? erase_in : ~erase_out;
      addr_out <= go_in ? addr_in : ~addr_out;
    end
  end
  // Memory changes only when the interlock is granted
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) commits_out <= 16'h0000;
    else if (grant_in) commits_out <= commits_out + 16'h0001;
  end
endmodule
`default_nettype wire

//--- tb/pmwg_guard_tb.sv
// Self-checking bench of the program memory write guard
`timescale 1ns/1ps
`default_nettype none
`include "pmwg_consts.svh"
module pmwg_guard_tb;
  import pmwg_pkg::*;
  logic clk_sys_in = 1'b0, resetn_in = 1'b0, cfg_load_in = 1'b0, go = 1'b0, erase = 1'b0;
  logic nvm_req_in, nvm_erase_in, nvm_grant_out, nvm_deny_out, prog_grant_out, prog_deny_out, device_reset_out;
  logic prog_req_in = 1'b0, prog_write_in = 1'b0, reg_wr_in = 1'b0, reg_rd_in = 1'b0;
  logic [15:0] cfg_word_in = 16'hffff, reg_wdata_in = 16'h0000, reg_rdata_out, commits, seed = 16'h005e;
  logic [3:0] reg_addr_in = 4'h0;
  pmwg_addr_t go_addr = '0, prog_addr_in = '0, nvm_addr_in;
  int err_count = 0, n_compared = 0;
  logic [15:0] exp_commits = 16'h0000;
  logic [15:0] seed_tab [7] = '{16'hffff, 16'hfbff, 16'hf405, 16'hf6a0, 16'hf1ff, 16'hc405, 16'hf400};
  pmwg_guard pmwg_guard_i (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .cfg_load_in(cfg_load_in),
    .cfg_word_in(cfg_word_in), .nvm_req_in(nvm_req_in), .nvm_erase_in(nvm_erase_in), .nvm_addr_in(nvm_addr_in),
    .nvm_grant_out(nvm_grant_out), .nvm_deny_out(nvm_deny_out), .prog_req_in(prog_req_in),
    .prog_write_in(prog_write_in), .prog_addr_in(prog_addr_in), .prog_grant_out(prog_grant_out),
    .prog_deny_out(prog_deny_out), .device_reset_out(device_reset_out), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out));
  pmwg_seq_model pmwg_seq_model_i (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .go_in(go), .erase_in(erase),
    .addr_in(go_addr), .grant_in(nvm_grant_out), .req_out(nvm_req_in), .erase_out(nvm_erase_in),
    .addr_out(nvm_addr_in), .commits_out(commits));
  initial forever #2.5 clk_sys_in = ~clk_sys_in;
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  function automatic logic seg_hit(input logic [15:0] c, input logic [14:0] p);
    return (!c[11] && (c[9] ? p >= {6'h00, c[8:0]} : p <= {6'h00, c[8:0]})) || (!c[10] && p == 15'h00ff);
  endfunction
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic print_verdict();
    if (err_count == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic reg_rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk_sys_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b0;
    #1 chk("reg_rdata", reg_rdata_out, e);
  endtask
  // Request through the sequencer model; answer lands two edges after go
  task automatic nonvolatile_memory(input pmwg_addr_t a, input logic d);
    @(posedge clk_sys_in);
    go_addr <= a;
    erase <= a[0];
    go <= 1'b1;
    @(posedge clk_sys_in);
    go <= 1'b0;
    @(posedge clk_sys_in);
    #1 chk("nvm_grant_deny", {14'h0000, nvm_grant_out, nvm_deny_out}, {14'h0000, !d, d});
    if (!d) exp_commits++;
  endtask
  task automatic prog(input pmwg_addr_t a, input logic wr, input logic d);
    @(posedge clk_sys_in);
    prog_req_in <= 1'b1;
    prog_write_in <= wr;
    prog_addr_in <= a;
    @(posedge clk_sys_in);
    prog_req_in <= 1'b0;
    prog_addr_in <= ~a;
    #1 chk("prog_grant_deny", {14'h0000, prog_grant_out, prog_deny_out}, {14'h0000, !d, d});
  endtask
  // Load a word, then probe both ports around the segment edges and the last page
  task automatic probe(input logic [15:0] c);
    logic [14:0] s;
    logic [14:0] pl [7];
    s = {6'h00, c[8:0]};
    @(posedge clk_sys_in);
    cfg_word_in <= c;
    cfg_load_in <= 1'b1;
    @(posedge clk_sys_in);
    cfg_load_in <= 1'b0;
    reg_rd(`PMWG_REG_CFG, {2'b00, c[13:0]});
    pl = '{s - 15'h0001, s, s + 15'h0001, 15'h00fe, 15'h00ff, 15'h0100, {6'h00, seed[8:0]}};
    for (int i = 0; i < 7; i++) begin
      seed = lfsr(seed);
      nonvolatile_memory({pl[i], seed[8:0]}, pl[i] > 15'h00ff || !c[12] || seg_hit(c, pl[i]));
      prog({pl[i], seed[9:1]}, seed[10], pl[i] > 15'h00ff || !c[13] || (seed[10] && seg_hit(c, pl[i])));
    end
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge clk_sys_in);
    chk("reset_outputs", {11'h000, nvm_grant_out, nvm_deny_out, prog_grant_out, prog_deny_out,
      device_reset_out}, 16'h0000);
    resetn_in <= 1'b1;
    nonvolatile_memory(24'h000200, 1'b1);
    prog(24'h000200, 1'b0, 1'b1);
    reg_rd(`PMWG_REG_CAUSE, 16'h0103);
    reg_rd(`PMWG_REG_CTRL, `PMWG_CTRL_RESET);
    reg_wr(`PMWG_REG_CTRL, 16'h0001);
    reg_rd(`PMWG_REG_CTRL, 16'h0001);
    reg_rd(4'h7, 16'h0000);
    foreach (seed_tab[k]) probe(seed_tab[k]);
    for (int k = 0; k < 20; k++) begin
      seed = lfsr(seed);
      probe(seed);
    end
    reg_rd(`PMWG_REG_STATUS, 16'h0007);
    reg_wr(`PMWG_REG_STATUS, 16'h0003);
    reg_rd(`PMWG_REG_STATUS, 16'h0004);
    reg_wr(`PMWG_REG_DENY_CNT, 16'h0000);
    nonvolatile_memory(24'hfffe00, 1'b1);
    reg_rd(`PMWG_REG_DENY_CNT, `PMWG_CNT_ONE);
    chk("commits", commits, exp_commits);
    @(posedge clk_sys_in);
    resetn_in <= 1'b0;
    @(posedge clk_sys_in);
    resetn_in <= 1'b1;
    reg_rd(`PMWG_REG_CTRL, `PMWG_CTRL_RESET);
    nonvolatile_memory(24'h000200, 1'b1);
    reg_rd(`PMWG_REG_CAUSE, 16'h0003);
    print_verdict();
  end
  initial begin
    #200000;
    err_count++;
    print_verdict();
  end
endmodule
`default_nettype wire
